// ---- rtl/fan_limit_pkg.sv ----
// Constants, register map and carrier types for the fan thermal limit bank.
// Assumes one 20 MHz clock and a classic Wishbone master in front of the bank.
// Notes on behaviour
// - Above start temperature fan ramps up from minimum
// - Lock freezes start, limit, test, offset registers
// - Any critical channel forces all PWM full
// - Critical limit code 0x80 disables fail-safe
// - Full duty held until below limit minus hysteresis
// - Pin output asserts low a quarter above limit
// - Four-bit hysteresis per channel, up to fifteen
// - Below start, minimum duty until start minus hysteresis
// - Same hysteresis releases the critical condition
// - Test bit zero enters and leaves tree mode
// - Remote 1 offset added, quarter degree steps
// - Local offset added, quarter degree steps
package fan_limit_pkg;

  localparam int NUM_CH     = 3;           // Remote 1, local, remote 2
  localparam int MEAS_W     = 10;          // Signed reading, quarter degree per count
  localparam int CORR_W     = 11;          // Corrected reading, one guard bit
  localparam int ADR_W      = 10;          // Byte address width on the bus

  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_START_R1  = 8'h67;
  localparam logic [7:0] IDX_START_LOC = 8'h68;
  localparam logic [7:0] IDX_START_R2  = 8'h69;
  localparam logic [7:0] IDX_CRIT_R1   = 8'h6a;
  localparam logic [7:0] IDX_CRIT_LOC  = 8'h6b;
  localparam logic [7:0] IDX_CRIT_R2   = 8'h6c;
  localparam logic [7:0] IDX_HYST_R1L  = 8'h6d;
  localparam logic [7:0] IDX_HYST_R2   = 8'h6e;
  localparam logic [7:0] IDX_XOR_TEST  = 8'h6f;
  localparam logic [7:0] IDX_OFS_R1    = 8'h70;
  localparam logic [7:0] IDX_OFS_LOC   = 8'h71;
  localparam logic [7:0] IDX_CONTROL   = 8'h74;
  localparam logic [7:0] IDX_IRQ_STAT  = 8'h75;
  localparam logic [7:0] IDX_IRQ_MASK  = 8'h76;
  localparam logic [7:0] IDX_CH_STATE  = 8'h77;

  // Values after reset
  localparam logic [7:0] RST_START     = 8'h5a;
  localparam logic [7:0] RST_CRIT      = 8'h64;
  localparam logic [7:0] RST_HYST_R1L  = 8'h44;
  localparam logic [7:0] RST_HYST_R2   = 8'h40;
  localparam logic [7:0] RST_ZERO      = 8'h00;

  // Field positions
  localparam int CTRL_LOCK_BIT    = 0;     // Sticky configuration lock
  localparam int CTRL_PIN_OUT_BIT = 1;     // Overtemp pin used as output
  localparam int XOR_EN_BIT       = 0;     // xor_test_enable_bit
  localparam int HYST_HI_LSB      = 4;     // Upper nibble of a hysteresis byte
  localparam int IRQ_START_LSB    = 0;     // Fan start events, one per channel
  localparam int IRQ_CRIT_LSB     = 3;     // Critical entry events
  localparam int IRQ_W            = 6;

  localparam logic [7:0] CRIT_DISABLE = 8'h80;  // Limit code that turns fail-safe off
  localparam logic [7:0] FULL_DUTY    = 8'hff;  // 100% duty

  // Per-channel thresholds handed to a channel
  typedef struct packed {
    logic [7:0] start;                     // fan_start_temperature
    logic [7:0] crit;                      // Critical limit
    logic [3:0] hyst;                      // Hysteresis, whole degrees
  } chan_cfg_t;

  // Per-channel results
  typedef struct packed {
    logic       fan_on;                    // Fan running
    logic       crit;                      // Critical condition held
    logic       over_pin;                  // Overtemp pin request
    logic       start_evt;                 // Pulse on fan start
    logic       crit_evt;                  // Pulse on critical entry
    logic [7:0] duty;                      // Requested duty
  } chan_out_t;

endpackage : fan_limit_pkg

// ---- rtl/fan_channel.sv ----
// One temperature channel: start/critical thresholds with hysteresis and duty.
// Assumes an offset-corrected reading in quarter degrees, synchronous inputs.
`timescale 1ns/1ps
module fan_channel
  import fan_limit_pkg::*;
(
  input  wire logic                     i_ref_clk,   // 20 MHz clock
  input  wire logic                     i_nrst,      // Async reset, active low
  input  wire chan_cfg_t                i_cfg,       // Thresholds
  input  wire logic signed [CORR_W-1:0] i_temp_q,    // Corrected reading
  input  wire logic [7:0]               i_min_duty,  // minimum_duty
  input  wire logic [2:0]               i_span_code, // temperature_span, 2^code degrees
  output chan_out_t                     o_stat       // Registered results
);

  typedef struct packed {
    chan_out_t st;                         // All outputs live here
  } ch_state_t;

  ch_state_t                state_reg;     // Registered state
  ch_state_t                state_next;    // Next state
  logic signed [CORR_W-1:0] t_deg;         // Whole degrees
  logic signed [CORR_W-1:0] start_s;       // Start, sign extended
  logic signed [CORR_W-1:0] crit_s;        // Limit, sign extended
  logic signed [CORR_W-1:0] hyst_s;        // Hysteresis, zero extended
  logic signed [CORR_W-1:0] dt;            // Degrees above start
  logic [8:0]               dt_c;          // Clamped to the span
  logic [16:0]              prod;          // Duty increment before scaling
  logic [8:0]               sum;           // Duty with carry
  logic                     crit_en;       // Fail-safe enabled

  // Threshold logic and duty computation
  always_comb begin
    state_next = state_reg;
    t_deg   = i_temp_q >>> 2;
    start_s = {{(CORR_W-8){i_cfg.start[7]}}, i_cfg.start};
    crit_s  = {{(CORR_W-8){i_cfg.crit[7]}}, i_cfg.crit};
    hyst_s  = {{(CORR_W-4){1'b0}}, i_cfg.hyst};
    crit_en = (i_cfg.crit != CRIT_DISABLE);
    // Fan on above start, off only once down to start minus hysteresis
    if (t_deg > start_s) begin
      state_next.st.fan_on = 1'b1;
    end else if (t_deg <= start_s - hyst_s) begin
      state_next.st.fan_on = 1'b0;
    end
    // Critical held until below limit minus the same hysteresis
    if (!crit_en) begin
      state_next.st.crit = 1'b0;
    end else if (t_deg > crit_s) begin
      state_next.st.crit = 1'b1;
    end else if (t_deg < crit_s - hyst_s) begin
      state_next.st.crit = 1'b0;
    end
    // Pin condition compares in quarter degrees: limit plus one count
    state_next.st.over_pin = crit_en && (i_temp_q >= ((crit_s <<< 2) + 11'sd1));
    state_next.st.start_evt = state_next.st.fan_on & ~state_reg.st.fan_on;
    state_next.st.crit_evt  = state_next.st.crit & ~state_reg.st.crit;
    // Linear ramp across the span; product avoids a divider
    dt = t_deg - start_s;
    if (dt <= 0) begin
      dt_c = 9'h000;
    end else if (dt > (11'sd1 <<< i_span_code)) begin
      dt_c = 9'(1 << i_span_code);
    end else begin
      dt_c = dt[8:0];
    end
    // Operands widened first so the product keeps all of its bits
    prod = 17'(FULL_DUTY - i_min_duty) * 17'(dt_c);
    sum  = 9'({1'b0, i_min_duty} + 9'(prod >> i_span_code));
    if (!state_next.st.fan_on) begin
      state_next.st.duty = 8'h00;
    end else if (sum[8]) begin
      state_next.st.duty = FULL_DUTY;
    end else begin
      state_next.st.duty = sum[7:0];
    end
  end

  // State register
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign o_stat = state_reg.st;

endmodule : fan_channel

// ---- rtl/fan_thermal_limit_registers.sv ----
// Fan thermal limit register bank with Wishbone slave, channels and interrupt.
// Assumes synchronous readings from the measurement engine and a classic
// Wishbone master that holds each request until it sees ack.
//
// Register access over Wishbone was left to the implementer.
`timescale 1ns/1ps
module fan_thermal_limit_registers
  import fan_limit_pkg::*;
(
  input  wire logic                          i_ref_clk,    // 20 MHz clock
  input  wire logic                          i_nrst,       // Async reset, active low
  input  wire logic                          i_wb_cyc,     // Bus cycle
  input  wire logic                          i_wb_stb,     // Strobe
  input  wire logic                          i_wb_we,      // Write enable
  input  wire logic [ADR_W-1:0]              i_wb_adr,     // Byte address
  input  wire logic [31:0]                   i_wb_dat,     // Write data
  input  wire logic [3:0]                    i_wb_sel,     // Byte selects
  output logic [31:0]                        o_wb_dat,     // Read data
  output logic                               o_wb_ack,     // Acknowledge
  input  wire logic [NUM_CH-1:0][MEAS_W-1:0] i_temp_meas,  // Raw readings, quarter degrees
  input  wire logic [NUM_CH-1:0][7:0]        i_min_duty,   // minimum_duty per PWM
  input  wire logic [NUM_CH-1:0][2:0]        i_span_code,  // temperature_span per channel
  output logic [NUM_CH-1:0][7:0]             o_pwm_duty,   // Duty request per PWM
  output logic                               o_overtemp_o, // Overtemp pin level
  output logic                               o_overtemp_oe,// Overtemp pin drive enable
  output logic                               o_xor_test,   // Tree test mode
  output logic                               o_irq         // Level interrupt
);

  // Whole state of the bank
  typedef struct packed {
    logic [NUM_CH-1:0][7:0] start;         // Start temperatures
    logic [NUM_CH-1:0][7:0] crit;          // Critical limits
    logic [7:0]             hyst_r1l;      // Remote 1 high nibble, local low
    logic [7:0]             hyst_r2;       // Remote 2 high nibble
    logic [7:0]             xor_test;      // Test enable register
    logic [7:0]             ofs_r1;        // Remote 1 offset
    logic [7:0]             ofs_loc;       // Local offset
    logic [7:0]             control;       // Lock and pin mode
    logic [IRQ_W-1:0]       irq_stat;      // Sticky events
    logic [IRQ_W-1:0]       irq_mask;      // Event enables
    logic                   ack;           // Bus acknowledge
    logic [7:0]             rdata;         // Latched read byte
  } bank_state_t;

  bank_state_t                           state_reg;   // Registered state
  bank_state_t                           state_next;  // Next state
  chan_cfg_t [NUM_CH-1:0]                ch_cfg;      // Thresholds per channel
  chan_out_t [NUM_CH-1:0]                ch_out;      // Channel results
  logic signed [NUM_CH-1:0][CORR_W-1:0]  temp_corr;   // Corrected readings
  logic [7:0]                            idx;         // Register index
  logic                                  idx_ok;      // Address is word aligned
  logic                                  bus_req;     // Request present
  logic                                  wr_now;      // Write takes effect
  logic                                  locked;      // Lock bit
  logic [IRQ_W-1:0]                      evt;         // Event pulses
  logic                                  any_crit;    // Some channel critical
  logic                                  any_pin;     // Some pin request
  logic [7:0]                            wbyte;       // Low write byte
  logic [7:0]                            rd_mux;      // Read selection

  // Offsets are sign extended quarter degrees; remote 2 has none here
  always_comb begin
    temp_corr[0] = $signed({i_temp_meas[0][MEAS_W-1], i_temp_meas[0]})
                 + $signed({{(CORR_W-8){state_reg.ofs_r1[7]}}, state_reg.ofs_r1});
    temp_corr[1] = $signed({i_temp_meas[1][MEAS_W-1], i_temp_meas[1]})
                 + $signed({{(CORR_W-8){state_reg.ofs_loc[7]}}, state_reg.ofs_loc});
    temp_corr[2] = $signed({i_temp_meas[2][MEAS_W-1], i_temp_meas[2]});
  end

  // Thresholds handed to the channels
  always_comb begin
    ch_cfg[0].hyst = state_reg.hyst_r1l[HYST_HI_LSB +: 4];
    ch_cfg[1].hyst = state_reg.hyst_r1l[3:0];
    ch_cfg[2].hyst = state_reg.hyst_r2[HYST_HI_LSB +: 4];
    for (int c = 0; c < NUM_CH; c++) begin
      ch_cfg[c].start = state_reg.start[c];
      ch_cfg[c].crit  = state_reg.crit[c];
    end
  end

  // One channel per reading
  genvar g;
  generate
    for (g = 0; g < NUM_CH; g++) begin : g_ch
      fan_channel u_ch (
        .i_ref_clk   (i_ref_clk),
        .i_nrst      (i_nrst),
        .i_cfg       (ch_cfg[g]),
        .i_temp_q    (temp_corr[g]),
        .i_min_duty  (i_min_duty[g]),
        .i_span_code (i_span_code[g]),
        .o_stat      (ch_out[g])
      );
      assign evt[IRQ_START_LSB + g] = ch_out[g].start_evt;
      assign evt[IRQ_CRIT_LSB + g]  = ch_out[g].crit_evt;
    end
  endgenerate

  // Fail-safe: any critical channel overrides every PWM
  always_comb begin
    any_crit = 1'b0;
    any_pin  = 1'b0;
    for (int c = 0; c < NUM_CH; c++) begin
      any_crit = any_crit | ch_out[c].crit;
      any_pin  = any_pin | ch_out[c].over_pin;
    end
    for (int c = 0; c < NUM_CH; c++) begin
      o_pwm_duty[c] = any_crit ? FULL_DUTY : ch_out[c].duty;
    end
  end

  // Bus decode; unmapped indices answer with zero and ignore writes
  always_comb begin
    idx     = 8'(i_wb_adr >> 2);
    idx_ok  = (i_wb_adr[1:0] == 2'b00);
    bus_req = i_wb_cyc & i_wb_stb;
    wr_now  = bus_req & i_wb_we & state_reg.ack & i_wb_sel[0] & idx_ok;
    locked  = state_reg.control[CTRL_LOCK_BIT];
    wbyte   = i_wb_dat[7:0];
  end

  // Read multiplexer
  always_comb begin
    rd_mux = 8'h00;
    if (idx_ok) begin
      case (idx)
        IDX_START_R1:  rd_mux = state_reg.start[0];
        IDX_START_LOC: rd_mux = state_reg.start[1];
        IDX_START_R2:  rd_mux = state_reg.start[2];
        IDX_CRIT_R1:   rd_mux = state_reg.crit[0];
        IDX_CRIT_LOC:  rd_mux = state_reg.crit[1];
        IDX_CRIT_R2:   rd_mux = state_reg.crit[2];
        IDX_HYST_R1L:  rd_mux = state_reg.hyst_r1l;
        IDX_HYST_R2:   rd_mux = state_reg.hyst_r2;
        IDX_XOR_TEST:  rd_mux = state_reg.xor_test;
        IDX_OFS_R1:    rd_mux = state_reg.ofs_r1;
        IDX_OFS_LOC:   rd_mux = state_reg.ofs_loc;
        IDX_CONTROL:   rd_mux = state_reg.control;
        IDX_IRQ_STAT:  rd_mux = 8'(state_reg.irq_stat);
        IDX_IRQ_MASK:  rd_mux = 8'(state_reg.irq_mask);
        // Live channel state: fan running low bits, critical above
        IDX_CH_STATE:  rd_mux = {1'b0, any_pin, ch_out[2].crit, ch_out[1].crit, ch_out[0].crit,
                                 ch_out[2].fan_on, ch_out[1].fan_on, ch_out[0].fan_on};
        default:       rd_mux = 8'h00;
      endcase
    end
  end

  // Next state: writes, ack and interrupt status
  always_comb begin
    state_next = state_reg;
    // Ack one cycle after the request; dropped the cycle after it was given
    state_next.ack = bus_req & ~state_reg.ack;
    if (bus_req & ~state_reg.ack) begin
      state_next.rdata = rd_mux;
    end
    if (wr_now) begin
      case (idx)
        IDX_START_R1: begin
          if (!locked) state_next.start[0] = wbyte;
        end
        IDX_START_LOC: begin
          if (!locked) state_next.start[1] = wbyte;
        end
        IDX_START_R2: begin
          if (!locked) state_next.start[2] = wbyte;
        end
        IDX_CRIT_R1: begin
          if (!locked) state_next.crit[0] = wbyte;
        end
        IDX_CRIT_LOC: begin
          if (!locked) state_next.crit[1] = wbyte;
        end
        IDX_CRIT_R2: begin
          if (!locked) state_next.crit[2] = wbyte;
        end
        // Hysteresis is not frozen by the lock
        IDX_HYST_R1L: begin
          state_next.hyst_r1l = wbyte;
        end
        IDX_HYST_R2: begin
          state_next.hyst_r2 = wbyte;
        end
        // Upper bits are stored as written; software should leave them zero
        IDX_XOR_TEST: begin
          if (!locked) state_next.xor_test = wbyte;
        end
        IDX_OFS_R1: begin
          if (!locked) state_next.ofs_r1 = wbyte;
        end
        IDX_OFS_LOC: begin
          if (!locked) state_next.ofs_loc = wbyte;
        end
        // Lock only clears on reset, so a stray write cannot unfreeze
        IDX_CONTROL: begin
          state_next.control[7:2] = 6'h00;
          state_next.control[CTRL_PIN_OUT_BIT] = wbyte[CTRL_PIN_OUT_BIT];
          state_next.control[CTRL_LOCK_BIT] = locked | wbyte[CTRL_LOCK_BIT];
        end
        IDX_IRQ_MASK: begin
          state_next.irq_mask = wbyte[IRQ_W-1:0];
        end
        IDX_IRQ_STAT: begin
          state_next.irq_stat = state_reg.irq_stat & ~wbyte[IRQ_W-1:0];
        end
        default: begin
          state_next.ack = state_next.ack;                            // Ignored write
        end
      endcase
    end
    // New events win over a clear in the same cycle
    state_next.irq_stat = state_next.irq_stat | evt;
  end

  // State register
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      state_reg.start    <= {NUM_CH{RST_START}};
      state_reg.crit     <= {NUM_CH{RST_CRIT}};
      state_reg.hyst_r1l <= RST_HYST_R1L;
      state_reg.hyst_r2  <= RST_HYST_R2;
      state_reg.xor_test <= RST_ZERO;
      state_reg.ofs_r1   <= RST_ZERO;
      state_reg.ofs_loc  <= RST_ZERO;
      state_reg.control  <= RST_ZERO;
      state_reg.irq_stat <= '0;
      state_reg.irq_mask <= '0;
      state_reg.ack      <= 1'b0;
      state_reg.rdata    <= RST_ZERO;
    end else begin
      state_reg <= state_next;
    end
  end

  // Outputs
  assign o_wb_ack      = state_reg.ack;
  assign o_wb_dat      = {24'h000000, state_reg.rdata};
  assign o_xor_test    = state_reg.xor_test[XOR_EN_BIT];
  // Open drain: level always low, drive enabled in pin output mode while a channel is a quarter over
  assign o_overtemp_o  = 1'b0;
  assign o_overtemp_oe = state_reg.control[CTRL_PIN_OUT_BIT] & any_pin;
  assign o_irq         = |(state_reg.irq_stat & state_reg.irq_mask);

endmodule : fan_thermal_limit_registers

// ---- testbench/fan_limit_properties.sv ----
// Concurrent checks on the top-level ports of the fan thermal limit bank.
// Assumes one clock domain; attached by the bind at the foot of this file.
`timescale 1ns/1ps
module fan_limit_checker
  import fan_limit_pkg::*;
(
  input wire logic                          i_ref_clk,     // Clock
  input wire logic                          i_nrst,        // Reset, active low
  input wire logic                          i_wb_cyc,      // Bus cycle
  input wire logic                          i_wb_stb,      // Strobe
  input wire logic                          i_wb_we,       // Write enable
  input wire logic [ADR_W-1:0]              i_wb_adr,      // Byte address
  input wire logic [3:0]                    i_wb_sel,      // Byte selects
  input wire logic [31:0]                   o_wb_dat,      // Read data
  input wire logic                          o_wb_ack,      // Acknowledge
  input wire logic [NUM_CH-1:0][7:0]        i_min_duty,    // Minimum duty
  input wire logic [NUM_CH-1:0][7:0]        o_pwm_duty,    // Duty requests
  input wire logic                          o_overtemp_o,  // Pin level
  input wire logic                          o_overtemp_oe, // Pin drive enable
  input wire logic                          o_xor_test     // Tree test mode
);
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_nrst);
  logic [7:0] idx;      // Register index of the request
  logic       req;      // Request not yet answered
  logic       mapped;   // Aligned access to a register
  logic       wr_xor;   // Write completing on the test register
  logic       floor_ok; // Every duty is off or at least its minimum
  assign idx    = i_wb_adr[9:2];
  assign req    = i_wb_cyc & i_wb_stb & ~o_wb_ack;
  assign mapped = (i_wb_adr[1:0] == 2'h0) && ((idx >= IDX_START_R1 && idx <= IDX_OFS_LOC) ||
                  (idx >= IDX_CONTROL && idx <= IDX_CH_STATE));
  assign wr_xor = o_wb_ack & i_wb_cyc & i_wb_stb & i_wb_we & i_wb_sel[0] & (idx == IDX_XOR_TEST);
  // Duty below minimum would stall a running fan
  always_comb begin
    floor_ok = 1'b1;
    for (int c = 0; c < NUM_CH; c++) begin
      if (o_pwm_duty[c] != 8'h00 && o_pwm_duty[c] < i_min_duty[c]) floor_ok = 1'b0;
    end
  end
  sequence s_req;
    req;
  endsequence
  sequence s_hole;
    s_req ##0 (!i_wb_we && !mapped);
  endsequence
  property p_ack_resp;      s_req |=> o_wb_ack;                          endproperty
  property p_ack_pulse;     o_wb_ack |=> !o_wb_ack;                      endproperty
  property p_ack_cause;     o_wb_ack |-> $past(req);                     endproperty
  property p_dat_upper;     o_wb_ack |-> (o_wb_dat[31:8] == 24'h0);      endproperty
  property p_unmapped_zero; s_hole |=> (o_wb_dat == 32'h0);              endproperty
  property p_xor_cause;     $changed(o_xor_test) |-> $past(wr_xor);      endproperty
  property p_pin_level;     o_overtemp_oe |-> !o_overtemp_o;             endproperty
  property p_duty_floor;    $stable(i_min_duty) |-> floor_ok;            endproperty
  a_ack_resp:      assert property (p_ack_resp) else $error("no ack after request");
  a_ack_pulse:     assert property (p_ack_pulse) else $error("ack longer than one cycle");
  a_ack_cause:     assert property (p_ack_cause) else $error("ack without request");
  a_dat_upper:     assert property (p_dat_upper) else $error("read data upper bits set");
  a_unmapped_zero: assert property (p_unmapped_zero) else $error("unmapped read not zero");
  a_xor_cause:     assert property (p_xor_cause) else $error("test mode changed without write");
  a_pin_level:     assert property (p_pin_level) else $error("pin driven high");
  a_duty_floor:    assert property (p_duty_floor) else $error("duty below minimum");
endmodule : fan_limit_checker

bind fan_thermal_limit_registers fan_limit_checker u_chk (.i_ref_clk(i_ref_clk), .i_nrst(i_nrst),
  .i_wb_cyc(i_wb_cyc), .i_wb_stb(i_wb_stb), .i_wb_we(i_wb_we), .i_wb_adr(i_wb_adr), .i_wb_sel(i_wb_sel),
  .o_wb_dat(o_wb_dat), .o_wb_ack(o_wb_ack), .i_min_duty(i_min_duty), .o_pwm_duty(o_pwm_duty),
  .o_overtemp_o(o_overtemp_o), .o_overtemp_oe(o_overtemp_oe), .o_xor_test(o_xor_test));

// ---- testbench/test_fan_thermal_limit_registers.sv ----
// Self-checking bench for the fan thermal limit bank over classic Wishbone.
// Assumes a 20 MHz clock; the bench drives every input itself.
`timescale 1ns/1ps
module test_fan_thermal_limit_registers;
  import fan_limit_pkg::*;
  localparam logic [7:0] MIN_D = 8'h40;                                 // Minimum duty on every PWM
  localparam logic [7:0] RAMP1 = MIN_D + ((FULL_DUTY - MIN_D) >> 3);    // One degree into an 8 degree span
  localparam logic [7:0] RST_TAB [11] = '{RST_START, RST_START, RST_START, RST_CRIT, RST_CRIT, RST_CRIT,
                                          RST_HYST_R1L, RST_HYST_R2, RST_ZERO, RST_ZERO, RST_ZERO};
  localparam logic [7:0] LCK_IDX [5] = '{IDX_START_R1, IDX_CRIT_R1, IDX_XOR_TEST, IDX_OFS_R1, IDX_OFS_LOC};
  localparam logic [7:0] LCK_VAL [5] = '{RST_START, CRIT_DISABLE, 8'h00, 8'hf8, 8'h04};
  logic                          i_ref_clk = 1'b0;          // Clock
  logic                          i_nrst    = 1'b0;          // Reset, active low
  logic                          cyc       = 1'b0;          // Bus cycle
  logic                          stb       = 1'b0;          // Strobe
  logic                          we        = 1'b0;          // Write
  logic [ADR_W-1:0]              adr       = '0;            // Byte address
  logic [31:0]                   wdat      = '0;            // Write data
  logic [3:0]                    sel       = '0;            // Byte selects
  logic [NUM_CH-1:0][MEAS_W-1:0] meas      = {3{10'h050}};  // 20 degrees everywhere
  logic [31:0]                   rdat;                      // Read data
  logic                          ack, pin, oe, xor_on, irq; // Single-bit results
  logic [NUM_CH-1:0][7:0]        duty;                      // Duty requests
  logic [7:0]                    rd;                        // Last read byte
  int                            n_fail = 0;                // Mismatches
  int                            cmp_count = 0;             // Comparisons
  int                            cycles = 0;                // Timeout counter
  always #25 i_ref_clk = ~i_ref_clk;
  fan_thermal_limit_registers dut (.i_ref_clk(i_ref_clk), .i_nrst(i_nrst), .i_wb_cyc(cyc), .i_wb_stb(stb),
    .i_wb_we(we), .i_wb_adr(adr), .i_wb_dat(wdat), .i_wb_sel(sel), .o_wb_dat(rdat), .o_wb_ack(ack),
    .i_temp_meas(meas), .i_min_duty({3{MIN_D}}), .i_span_code({3{3'h3}}), .o_pwm_duty(duty),
    .o_overtemp_o(pin), .o_overtemp_oe(oe), .o_xor_test(xor_on), .o_irq(irq));
  task automatic give_verdict();
    $display("Comparisons %0d, mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : give_verdict
  // Whole run should take a few hundred cycles; a hang is cut off here
  always @(posedge i_ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      n_fail++;
      give_verdict();
    end
  end
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // One classic cycle; entered just after a rising edge, holds until ack; only the run timeout ends a wait
  task automatic xfer(input logic w, input logic [7:0] idx, input logic [7:0] d, output logic [7:0] r);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= {idx, 2'h0}; wdat <= {24'h0, d}; sel <= 4'h1;
    do begin
      @(posedge i_ref_clk);
    end while (ack !== 1'b1);
    r = rdat[7:0];
    cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
    @(posedge i_ref_clk);
  endtask : xfer
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    xfer(1'b1, idx, d, rd);
  endtask : wr
  task automatic rdchk(input logic [7:0] idx, input logic [7:0] exp, input string what);
    xfer(1'b0, idx, 8'h00, rd);
    chk(what, exp, rd);
  endtask : rdchk
  // New reading, then time for channel, override and interrupt to settle
  task automatic temp(input int ch, input logic [MEAS_W-1:0] q);
    meas[ch] <= q;
    repeat (4) @(posedge i_ref_clk);
  endtask : temp
  initial begin
    repeat (20) @(posedge i_ref_clk);
    i_nrst <= 1'b1;
    @(posedge i_ref_clk);
    for (int i = 0; i < 11; i++) rdchk(IDX_START_R1 + 8'(i), RST_TAB[i], "reset value");
    rdchk(8'h60, 8'h00, "unmapped read");
    wr(IDX_HYST_R1L, 8'h54);
    rdchk(IDX_HYST_R1L, 8'h54, "hysteresis");
    temp(1, 10'd363); chk("pwm1 floor", 8'h00, duty[1]);
    temp(1, 10'd364); chk("pwm1 start", RAMP1, duty[1]);
    temp(1, 10'd392); chk("pwm1 span end", FULL_DUTY, duty[1]);
    temp(1, 10'd352); chk("pwm1 hold", MIN_D, duty[1]);
    temp(1, 10'd344); chk("pwm1 off", 8'h00, duty[1]);
    chk("irq masked", 8'h00, {7'h0, irq});
    wr(IDX_IRQ_MASK, 8'h08);
    temp(0, 10'd404); chk("pwm2 failsafe", FULL_DUTY, duty[2]);
    chk("pwm1 failsafe", FULL_DUTY, duty[1]);
    chk("irq raised", 8'h01, {7'h0, irq});
    temp(0, 10'd380); chk("crit hold", FULL_DUTY, duty[2]);
    temp(0, 10'd376); chk("crit release", 8'h00, duty[2]);
    wr(IDX_IRQ_STAT, 8'h08);
    repeat (2) @(posedge i_ref_clk);
    chk("irq cleared", 8'h00, {7'h0, irq});
    rdchk(IDX_IRQ_STAT, 8'h03, "irq status");
    wr(IDX_CONTROL, 8'h02);
    temp(0, 10'd401); chk("pin on", 8'h01, {7'h0, oe});
    temp(0, 10'd400); chk("pin off", 8'h00, {7'h0, oe});
    temp(0, 10'd080);
    wr(IDX_OFS_R1, 8'hf8);
    temp(0, 10'd368); chk("pwm0 offset off", 8'h00, duty[0]);
    temp(0, 10'd372); chk("pwm0 offset on", RAMP1, duty[0]);
    wr(IDX_OFS_LOC, 8'h04);
    temp(1, 10'd360); chk("pwm1 offset on", RAMP1, duty[1]);
    wr(IDX_CRIT_R1, CRIT_DISABLE);
    temp(0, 10'd440); chk("failsafe off", 8'h00, duty[2]);
    wr(IDX_XOR_TEST, 8'h01); chk("xor on", 8'h01, {7'h0, xor_on});
    wr(IDX_XOR_TEST, 8'h00); chk("xor off", 8'h00, {7'h0, xor_on});
    wr(IDX_CONTROL, 8'h03);
    for (int i = 0; i < 5; i++) begin
      wr(LCK_IDX[i], 8'h01);
      rdchk(LCK_IDX[i], LCK_VAL[i], "locked register");
    end
    give_verdict();
  end
endmodule : test_fan_thermal_limit_registers
